// ---- src/adcavg_defs.vh ----
// Constants for the result averager: register offsets, field positions, reset values, widths.
`ifndef ADCAVG_DEFS_VH
`define ADCAVG_DEFS_VH
`define ADCAVG_SMP_W 12
`define ADCAVG_ACC_W 22
`define ADCAVG_OFF_AVG 12'h000
`define ADCAVG_OFF_CONTROL_C 12'h004
`define ADCAVG_OFF_RESULT 12'h008
`define ADCAVG_OFF_FLAGS 12'h00c
`define ADCAVG_OFF_MASK 12'h010
`define ADCAVG_OFF_STATUS 12'h014
`define ADCAVG_AVG_CNT_LSB 0
`define ADCAVG_AVG_CNT_MSB 3
`define ADCAVG_AVG_ADJ_LSB 4
`define ADCAVG_AVG_ADJ_MSB 6
`define ADCAVG_CONTROL_C_RES_BIT 0
`define ADCAVG_CONTROL_C_EN_BIT 1
`define ADCAVG_FLAG_RDY_BIT 0
`define ADCAVG_FLAG_OVR_BIT 1
`define ADCAVG_CNT_MAX 4'ha
`define ADCAVG_AUTO_BASE 4'h4
`define ADCAVG_RST_AVG 7'h00
`define ADCAVG_RST_CONTROL_C 2'h0
`define ADCAVG_RST_MASK 2'h0
`define ADCAVG_RST_FLAG 1'b0
`endif

// ---- src/adcavg_shift.v ----
// Combined automatic and adjusting right shift of the accumulated sum.
`timescale 1ns/1ps
`include "adcavg_defs.vh"
module adcavg_shift (
  input wire [`ADCAVG_ACC_W-1:0] acc_sum,
  input wire [3:0] count_code,
  input wire [2:0] adjust_shift,
  output wire [15:0] shifted
);
  reg [3:0] auto_sh;
  wire [`ADCAVG_ACC_W-1:0] after_auto;
  wire [`ADCAVG_ACC_W-1:0] after_adj;

  // No automatic shift up to 16 samples, then code minus four.
  always @* begin
    if (count_code > `ADCAVG_AUTO_BASE && count_code <= `ADCAVG_CNT_MAX) begin
      auto_sh = count_code - `ADCAVG_AUTO_BASE;
    end else begin
      auto_sh = 4'h0;
    end
  end

  // The two shifts add; software picks the adjust so the total suits averaging or decimation.
  assign after_auto = acc_sum >> auto_sh;
  assign after_adj = after_auto >> adjust_shift;
  // At most 16 bits survive; a wrong adjust setting simply truncates.
  assign shifted = after_adj[15:0];
endmodule // adcavg_shift

// ---- src/adcavg_top.v ----
// Result averager: accumulates converter samples, shifts, and offers the result over APB.
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "adcavg_defs.vh"
module adcavg_top (
  input wire clk,
  input wire rst_n,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire sample_valid,
  input wire [11:0] sample_data,
  output reg result_valid,
  output reg [15:0] result_data,
  output wire irq
);
  // Register map, each register one aligned 32-bit word, unused bits read as zero:
  //   0x00 averaging control: bits 3:0 sample count code, bits 6:4 adjust shift.
  //   0x04 control: bit 0 resolution select, bit 1 engine enable.
  //   0x08 result: bits 15:0 hold the last delivered result, read only.
  //   0x0c interrupt flags: bit 0 result ready, bit 1 overrun; write one to clear.
  //   0x10 interrupt mask: same layout as the flags, a one lets the flag drive irq.
  //   0x14 status: bits 10:0 samples taken so far, bit 11 engine accumulating.
  // Any other address answers with pslverr; writes to it are dropped and reads return zero.
  //
  // Bus timing: pready is always high, so every transfer is one setup and one access cycle.
  // Read data is loaded at the setup edge, which keeps prdata off the combinational path
  // from paddr at the cost of a register snapshot one cycle before the access edge.
  //
  // Clock enable: while clk_en is low every register holds, including prdata, and no
  // write or flag change takes effect; a bus transfer should not end while it is low.
  //
  // Sample timing: the engine takes a sample at every edge with sample_valid high while it
  // accumulates. It enters the accumulating state one cycle after the enable bit is set,
  // so a sample in that first cycle is dropped; the converter must start after that.
  // The sample that completes the count is not stored; it is added on the way into the
  // shifter, and result_valid rises at that same edge with result_data settled.
  //
  // Shift: the automatic part is the count code minus four for codes five to ten and zero
  // otherwise; the adjust field adds to it. For a plain average software sets the adjust
  // to the code, capped at four, so the total equals the code. For extra resolution the
  // total is the number of extra bits, and 4^n samples must be taken. Anything wider than
  // sixteen bits after the shift is cut; the block does not saturate.
  //
  // Reserved count codes behave as a single sample, so a stray write cannot stall the
  // engine waiting for a count it will never reach.
  //
  // Overrun: a result that lands while the ready flag is still set also sets the overrun
  // flag. The older result is already gone by then, so software that polls slowly should
  // watch this flag rather than trust that every result was seen. Both flags are sticky
  // and only a write of one clears them.
  //
  // Clearing the enable bit drops the running sum and count without delivering a result.
  // Changing the count code during a run takes effect at once against the running count,
  // so software should change it only with the engine disabled or between results.

  localparam ST_IDLE = 1'b0;
  localparam ST_ACC = 1'b1;

  reg [6:0] averaging_control_reg;
  reg [1:0] control_c_reg;
  reg [15:0] result_reg;
  reg [1:0] interrupt_flags_reg;
  reg [1:0] mask_reg;
  reg state_reg;
  reg [`ADCAVG_ACC_W-1:0] acc_reg;
  reg [10:0] cnt_reg;
  reg [`ADCAVG_ACC_W-1:0] acc_next;
  reg [10:0] cnt_next;
  reg state_next;
  reg done;
  reg [10:0] target;
  reg [1:0] flag_set;
  wire [3:0] sample_count_code;
  wire [2:0] adjust_shift;
  wire resolution_select;
  wire avg_enable;
  wire [15:0] shifted;
  wire wr_en;
  wire rd_en;
  wire addr_ok;
  wire [`ADCAVG_ACC_W-1:0] sum_in;
  wire [`ADCAVG_ACC_W-1:0] sum_final;
  wire [15:0] result_pick;
  wire sel_avg;
  wire sel_control_c;
  wire sel_result;
  wire sel_flags;
  wire sel_mask;
  wire sel_status;
  wire last_sample;
  wire [1:0] flag_clear;

  assign sample_count_code = averaging_control_reg[`ADCAVG_AVG_CNT_MSB:`ADCAVG_AVG_CNT_LSB];
  assign adjust_shift = averaging_control_reg[`ADCAVG_AVG_ADJ_MSB:`ADCAVG_AVG_ADJ_LSB];
  assign resolution_select = control_c_reg[`ADCAVG_CONTROL_C_RES_BIT];
  assign avg_enable = control_c_reg[`ADCAVG_CONTROL_C_EN_BIT];

  // The slave answers in the first access cycle; unmapped addresses raise pslverr.
  assign pready = 1'b1;
  // Each register decodes its own word address; only the aligned offsets are mapped.
  assign sel_avg = (paddr == `ADCAVG_OFF_AVG);
  assign sel_control_c = (paddr == `ADCAVG_OFF_CONTROL_C);
  assign sel_result = (paddr == `ADCAVG_OFF_RESULT);
  assign sel_flags = (paddr == `ADCAVG_OFF_FLAGS);
  assign sel_mask = (paddr == `ADCAVG_OFF_MASK);
  assign sel_status = (paddr == `ADCAVG_OFF_STATUS);
  assign addr_ok = sel_avg | sel_control_c | sel_result | sel_flags | sel_mask | sel_status;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en = psel & penable & pwrite & clk_en;
  assign rd_en = psel & ~penable & ~pwrite & clk_en;

  // Reserved codes fall back to a single sample so the block never stalls.
  always @* begin
    if (sample_count_code <= `ADCAVG_CNT_MAX) begin
      target = 11'h001 << sample_count_code;
    end else begin
      target = 11'h001;
    end
  end

  // Samples are zero-extended into the 22-bit accumulator, which holds 1024 full-scale values.
  assign sum_in = {{(`ADCAVG_ACC_W-`ADCAVG_SMP_W){1'b0}}, sample_data};

  // The sample that completes the configured count closes the run.
  assign last_sample = (cnt_reg + 11'h001) >= target;

  // Accumulation engine: counts samples and signals the final one.
  always @* begin
    acc_next = acc_reg;
    cnt_next = cnt_reg;
    state_next = state_reg;
    done = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        acc_next = {`ADCAVG_ACC_W{1'b0}};
        cnt_next = 11'h000;
        if (avg_enable) begin
          state_next = ST_ACC;
        end
      end
      ST_ACC: begin
        if (!avg_enable) begin
          state_next = ST_IDLE;
        end else if (sample_valid) begin
          if (last_sample) begin
            done = 1'b1;
            acc_next = {`ADCAVG_ACC_W{1'b0}};
            cnt_next = 11'h000;
          end else begin
            acc_next = acc_reg + sum_in;
            cnt_next = cnt_reg + 11'h001;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // The final sample joins the sum inside the shifter path, saving a cycle of latency.
  assign sum_final = acc_reg + sum_in;

  adcavg_shift u_shift (
    .acc_sum(sum_final),
    .count_code(sample_count_code),
    .adjust_shift(adjust_shift),
    .shifted(shifted)
  );

  // Event sources: ready on each delivered result, overrun if a result lands while ready is still set.
  always @* begin
    flag_set = 2'b00;
    flag_set[`ADCAVG_FLAG_RDY_BIT] = done;
    flag_set[`ADCAVG_FLAG_OVR_BIT] = done & interrupt_flags_reg[`ADCAVG_FLAG_RDY_BIT];
  end

  // Without resolution select the raw sample passes, so averaging needs the bit set first.
  assign result_pick = resolution_select ? shifted : {4'h0, sample_data};

  // Engine state and result capture.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      acc_reg <= {`ADCAVG_ACC_W{1'b0}};
      cnt_reg <= 11'h000;
      result_reg <= 16'h0000;
      result_data <= 16'h0000;
      result_valid <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      cnt_reg <= cnt_next;
      result_valid <= done;
      if (done) begin
        // Without resolution select only single samples pass untouched; software must set it.
        result_reg <= result_pick;
        result_data <= result_pick;
      end
    end
  end

  // Configuration register writes; a write to an unmapped address changes nothing.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      averaging_control_reg <= `ADCAVG_RST_AVG;
      control_c_reg <= `ADCAVG_RST_CONTROL_C;
      mask_reg <= `ADCAVG_RST_MASK;
    end else if (clk_en) begin
      if (wr_en && sel_avg) begin
        averaging_control_reg <= pwdata[6:0];
      end
      if (wr_en && sel_control_c) begin
        control_c_reg <= pwdata[1:0];
      end
      if (wr_en && sel_mask) begin
        mask_reg <= pwdata[1:0];
      end
    end
  end

  // Writing a one to a flag clears it; the other bits of that write are ignored.
  assign flag_clear = (wr_en && sel_flags) ? pwdata[1:0] : 2'b00;

  // One sticky flag per event; a set in the same cycle as a clear wins, so no event is lost.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_flag
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          interrupt_flags_reg[gi] <= `ADCAVG_RST_FLAG;
        end else if (clk_en) begin
          if (flag_set[gi]) begin
            interrupt_flags_reg[gi] <= 1'b1;
          end else if (flag_clear[gi]) begin
            interrupt_flags_reg[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Read data is registered in the setup cycle and valid during the access phase.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        `ADCAVG_OFF_AVG: begin
          prdata <= {25'h0000000, averaging_control_reg};
        end
        `ADCAVG_OFF_CONTROL_C: begin
          prdata <= {30'h00000000, control_c_reg};
        end
        `ADCAVG_OFF_RESULT: begin
          prdata <= {16'h0000, result_reg};
        end
        `ADCAVG_OFF_FLAGS: begin
          prdata <= {30'h00000000, interrupt_flags_reg};
        end
        `ADCAVG_OFF_MASK: begin
          prdata <= {30'h00000000, mask_reg};
        end
        `ADCAVG_OFF_STATUS: begin
          prdata <= {20'h00000, state_reg, cnt_reg};
        end
        default: begin
          prdata <= 32'h00000000;
        end
      endcase
    end
  end

  // Level interrupt while any unmasked flag is set.
  assign irq = |(interrupt_flags_reg & mask_reg);
endmodule // adcavg_top

// ---- dv/adcavg_properties.sv ----
// Port checker for the result averager.
`timescale 1ns/1ps
module adcavg_properties (
  input wire clk,
  input wire rst_n,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire sample_valid,
  input wire result_valid,
  input wire [15:0] result_data,
  input wire irq
);
  reg [3:0] code_q;
  reg [1:0] mask_q;
  reg [10:0] cnt_q;
  wire wr_en = psel & penable & pwrite & clk_en;
  wire [10:0] need = (code_q <= 4'ha) ? (11'h1 << code_q) : 11'h1;
  // Shadow the count code and mask; a sample on the result cycle starts the next count.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= 4'h0;
      mask_q <= 2'h0;
      cnt_q <= 11'h0;
    end else begin
      if (wr_en && paddr == 12'h000) code_q <= pwdata[3:0];
      if (wr_en && paddr == 12'h010) mask_q <= pwdata[1:0];
      if (result_valid) cnt_q <= {10'h0, sample_valid};
      else if (sample_valid) cnt_q <= cnt_q + 11'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_count_per_result: assert property (result_valid |-> cnt_q == need) else $error("bad count");
  a_result_cause: assert property (result_valid |-> $past(sample_valid)) else $error("no sample");
  a_result_holds: assert property (!result_valid |-> $stable(result_data)) else $error("moved");
  a_irq_masked: assert property (mask_q == 2'h0 |-> !irq) else $error("irq masked");
  a_irq_ready: assert property (result_valid && mask_q[0] |-> irq) else $error("irq missing");
  a_err_unmapped: assert property (psel && penable && paddr > 12'h014 |-> pslverr) else $error("no err");
  a_err_mapped: assert property (psel && penable && paddr <= 12'h014 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("err");
  a_ready_high: assert property (pready) else $error("pready low");
  c_full: cover property (result_valid && need == 11'h400);
  c_irq: cover property (irq);
  c_err: cover property (psel && penable && pslverr);
endmodule // adcavg_properties

// ---- dv/adcavg_conv_model.sv ----
// Converter core model: emits a burst of samples on request.
`timescale 1ns/1ps
module adcavg_conv_model (
  input wire clk,
  input wire rst_n,
  input wire go,
  input wire [10:0] n,
  input wire gap,
  output reg sample_valid,
  output reg [11:0] sample_data
);
  reg [11:0] left;
  reg [11:0] val;
  reg ph;
  // Between samples the data lines flip so stale values are never mistaken for data.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left <= 12'h0;
      val <= 12'h9c4;
      ph <= 1'b0;
      sample_valid <= 1'b0;
      sample_data <= 12'h0;
    end else begin
      ph <= ~ph;
      if (left != 12'h0 && (!gap || ph) && !go) begin
        left <= left - 12'h1;
        sample_valid <= 1'b1;
        sample_data <= val;
        val <= val + 12'h6f3;
      end else begin
        if (go) left <= {1'b0, n};
        sample_valid <= 1'b0;
        sample_data <= ~sample_data;
      end
    end
  end
endmodule // adcavg_conv_model

// ---- dv/tb_adc_result_averager.sv ----
// Testbench for the result averager.
`timescale 1ns/1ps
module tb_adc_result_averager;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0;
  reg go = 1'b0;
  reg [10:0] n = 11'h0;
  reg gap = 1'b0;
  wire pready, pslverr, sample_valid, result_valid, irq;
  wire [31:0] prdata;
  wire [11:0] sample_data;
  wire [15:0] result_data;
  reg [31:0] rdat;
  reg rerr;
  reg [21:0] acc;
  integer num_errors = 0;
  integer n_checks = 0;
  integer cyc = 0;
  integer i;
  always #4 clk = ~clk;
  adcavg_top DUT (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_data(sample_data), .result_valid(result_valid),
    .result_data(result_data), .irq(irq));
  adcavg_conv_model u_conv (.clk(clk), .rst_n(rst_n), .go(go), .n(n), .gap(gap),
    .sample_valid(sample_valid), .sample_data(sample_data));
  // Expected sums are built from what the converter actually delivered.
  always @(posedge clk) begin
    if (sample_valid) acc <= acc + {10'h0, sample_data};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      final_report;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task xf(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // One averaging run; the shift is the automatic part plus the adjust field.
  task run_case(input [3:0] c, input [2:0] j, input g);
    reg [3:0] s;
    reg [21:0] q;
    begin
      s = ((c > 4'h4 && c <= 4'ha) ? c - 4'h4 : 4'h0) + {1'b0, j};
      xf(1'b1, 12'h000, {25'h0, j, c});
      acc = 22'h0;
      n <= (c <= 4'ha) ? (11'h1 << c) : 11'h1;
      gap <= g;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      while (result_valid !== 1'b1) @(negedge clk);
      q = acc >> s;
      chk({16'h0, result_data}, {16'h0, q[15:0]});
      xf(1'b0, 12'h008, 32'h0);
      chk(rdat, {16'h0, q[15:0]});
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // Main sequence: reset, bus checks, count codes zero to eleven, oversampling, interrupt handling.
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    xf(1'b0, 12'h004, 32'h0);
    chk(rdat, 32'h0);
    xf(1'b0, 12'h018, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    xf(1'b1, 12'h004, 32'h3);
    for (i = 0; i <= 10; i = i + 1) run_case(i[3:0], (i > 4) ? 3'h4 : i[2:0], i[0]);
    run_case(4'h8, 3'h0, 1'b0);
    run_case(4'h2, 3'h1, 1'b0);
    run_case(4'hb, 3'h0, 1'b0);
    xf(1'b0, 12'h00c, 32'h0);
    chk(rdat, 32'h3);
    chk({31'h0, irq}, 32'h0);
    xf(1'b1, 12'h010, 32'h1);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    xf(1'b1, 12'h00c, 32'h1);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    xf(1'b0, 12'h00c, 32'h0);
    chk(rdat, 32'h2);
    final_report;
  end
endmodule // tb_adc_result_averager
bind adcavg_top adcavg_properties u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .sample_valid(sample_valid), .result_valid(result_valid), .result_data(result_data), .irq(irq));
